// *** rtl/rxfsc_top.sv ***
// Receive FIFO status, control and last-read-frame pointer logic with an
// AHB-Lite register slave. Assumes the FIFO datapath on the same clock
// supplies fill level, frame pointers and one-cycle event strobes.
`include "rxfsc_consts.svh"

module rxfsc_top
  import rxfsc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // FIFO datapath
  input wire rxfsc_fifo_in_t fifo_in,
  // Requests and events
  output logic rx_fifo_error_event,
  output logic high_service_req,
  output logic frame_service_req
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // Helpers
  // ****************************************
  // Pointer value outside the 1024 byte memory
  function automatic logic ptr_illegal(input logic [15:0] v);
    ptr_illegal = (v > `RXFSC_PTR_MAX);
  endfunction : ptr_illegal

  // Sticky flag: set wins over a write-one clear
  function automatic logic sticky(input logic cur, input logic set,
                                  input logic clr);
    sticky = set | (cur & ~clr);
  endfunction : sticky

  function automatic rxfsc_reg_t decode(input logic [31:0] a);
    unique case ({a[15:2], 2'b00})
      `RXFSC_STATUS_OFS: decode = RXFSC_R_STATUS;
      `RXFSC_CTRL_OFS: decode = RXFSC_R_CTRL;
      `RXFSC_LAST_READ_FRAME_POINTER_OFS: decode = RXFSC_R_LAST_READ_FRAME_POINTER;
      default: decode = RXFSC_R_NONE;
    endcase
  endfunction : decode

  rxfsc_state_t s_q;
  rxfsc_state_t s_d;
  logic addr_phase;
  logic wr_now;
  logic [31:0] status_word;
  logic [31:0] ctrl_word;
  logic [10:0] free_bytes;
  logic [10:0] gr_bytes;
  logic frames_pending;
  rxfsc_flags_t set_ev;
  rxfsc_flags_t clr_ev;

  assign addr_phase = hsel & hready & htrans[1];
  assign wr_now = s_q.dwrite;
  assign free_bytes = `RXFSC_DEPTH - fifo_in.level;
  assign gr_bytes = {8'h00, s_q.ctrl.last_transfer_granularity};
  assign frames_pending = (fifo_in.last_write_frame_ptr != s_q.last_read_frame_pointer);

  // Reserved and read-only bits are fixed by the read mux
  assign status_word = {s_q.flags.ip, 3'h0, s_q.lanes, s_q.flags.fae,
                        s_q.flags.receive_wait_flag, s_q.flags.uf, s_q.flags.of,
                        s_q.frame_ready, s_q.full, s_q.alarm, s_q.empty,
                        16'h0000};
  assign ctrl_word = {3'h0, s_q.ctrl.timer_mode, s_q.ctrl.frame_mode_enable,
                      s_q.ctrl.last_transfer_granularity, s_q.ctrl.masks,
                      `RXFSC_CT_FIXED, s_q.ctrl.counter};

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    set_ev = '0;
    clr_ev = '0;

    // Bus: registered address phase, zero-wait data phase
    s_d.dwrite = 1'b0;
    s_d.didx = RXFSC_R_NONE;
    s_d.hrdata = 32'h0000_0000;
    if (addr_phase) begin
      s_d.dwrite = hwrite;
      s_d.didx = decode(haddr);
      if (!hwrite) begin
        unique case (decode(haddr))
          RXFSC_R_STATUS: s_d.hrdata = status_word;
          RXFSC_R_CTRL: s_d.hrdata = ctrl_word;
          RXFSC_R_LAST_READ_FRAME_POINTER: s_d.hrdata = {22'h000000, s_q.last_read_frame_pointer};
          RXFSC_R_NONE: s_d.hrdata = 32'h0000_0000;
        endcase
      end
    end

    // Only ones in w1c positions clear
    if (wr_now && s_q.didx == RXFSC_R_STATUS) begin
      clr_ev.ip = hwdata[`RXFSC_ST_IP];
      clr_ev.fae = hwdata[`RXFSC_ST_FLAGS_LO + 4];
      clr_ev.receive_wait_flag = hwdata[`RXFSC_ST_FLAGS_LO + 3];
      clr_ev.uf = hwdata[`RXFSC_ST_FLAGS_LO + 2];
      clr_ev.of = hwdata[`RXFSC_ST_FLAGS_LO + 1];
    end
    if (wr_now && s_q.didx == RXFSC_R_CTRL) begin
      s_d.ctrl.timer_mode = hwdata[`RXFSC_CT_TIMER];
      s_d.ctrl.frame_mode_enable = hwdata[`RXFSC_CT_FRAME_MODE_ENABLE];
      s_d.ctrl.last_transfer_granularity =
        hwdata[`RXFSC_CT_GR_LO +: 3];
      s_d.ctrl.masks = hwdata[`RXFSC_CT_MASK_LO +: 5];
      s_d.ctrl.counter = hwdata[15:0];
    end

    // Illegal pointer from datapath or this register
    set_ev.ip = (fifo_in.ptr_wr & ptr_illegal(fifo_in.ptr_wr_val)) |
                (wr_now && s_q.didx == RXFSC_R_LAST_READ_FRAME_POINTER &&
                 ptr_illegal(hwdata[15:0])) |
                (wr_now && s_q.didx == RXFSC_R_LAST_READ_FRAME_POINTER && |hwdata[31:16]);
    // Accept error counts only in frame mode
    set_ev.fae = fifo_in.frame_rejected & s_q.ctrl.frame_mode_enable;
    // Writer held off for lack of room
    set_ev.receive_wait_flag = fifo_in.mac_stall;
    set_ev.uf = fifo_in.underflow_evt;
    set_ev.of = fifo_in.overflow_evt;

    s_d.flags.ip = sticky(s_q.flags.ip, set_ev.ip, clr_ev.ip);
    s_d.flags.fae = sticky(s_q.flags.fae, set_ev.fae, clr_ev.fae);
    s_d.flags.receive_wait_flag = sticky(s_q.flags.receive_wait_flag, set_ev.receive_wait_flag, clr_ev.receive_wait_flag);
    s_d.flags.uf = sticky(s_q.flags.uf, set_ev.uf, clr_ev.uf);
    s_d.flags.of = sticky(s_q.flags.of, set_ev.of, clr_ev.of);

    // Debug write; out-of-range values are kept to ten bits
    if (wr_now && s_q.didx == RXFSC_R_LAST_READ_FRAME_POINTER) begin
      s_d.last_read_frame_pointer = hwdata[9:0];
    end
    // Advance on reads that reach a frame boundary, frame mode only
    if (fifo_in.boundary_valid && s_q.ctrl.frame_mode_enable) begin
      s_d.last_read_frame_pointer = fifo_in.frame_end_ptr;
    end
    // Latch the lane of the last boundary seen
    if (fifo_in.boundary_valid) begin
      s_d.lanes = fifo_in.boundary_lanes;
    end

    // Complete frames unread, frame mode only
    s_d.frame_ready = s_q.ctrl.frame_mode_enable & frames_pending;
    s_d.full = (fifo_in.level >= `RXFSC_DEPTH);
    s_d.empty = (fifo_in.level == 11'h000);

    if (free_bytes < {1'b0, fifo_in.alarm_threshold}) begin
      s_d.alarm = 1'b1;
    // Frame mode overrides granularity: drop only when empty
    end else if (s_q.ctrl.frame_mode_enable) begin
      if (fifo_in.level == 11'h000) begin
        s_d.alarm = 1'b0;
      end
    // Drop when fewer bytes than granularity remain
    end else if (fifo_in.level < gr_bytes) begin
      s_d.alarm = 1'b0;
    end
    // High request follows the alarm, never the timer
    s_d.high_req = s_d.alarm;

    s_d.err_evt = |(s_q.flags & ~s_q.ctrl.masks);

    // Frame request timer, 64-cycle prescaled ticks
    s_d.frame_req = 1'b0;
    unique case (s_q.tstate)
      RXFSC_T_OFF: begin
        s_d.frame_req = s_q.frame_ready;
        s_d.prescale = 6'h00;
        s_d.ticks = 16'h0000;
        if (s_q.ctrl.timer_mode && s_q.ctrl.frame_mode_enable) begin
          s_d.tstate = RXFSC_T_WAIT;
          s_d.frame_req = 1'b0;
        end
      end
      RXFSC_T_WAIT: begin
        s_d.prescale = s_q.prescale + 6'h01;
        if (s_q.prescale == `RXFSC_PRESCALE_LAST) begin
          s_d.ticks = s_q.ticks + 16'h0001;
          if (s_q.ticks + 16'h0001 >= s_q.ctrl.counter) begin
            s_d.tstate = RXFSC_T_FIRE;
          end
        end
      end
      RXFSC_T_FIRE: begin
        s_d.frame_req = s_q.frame_ready;
        // Fire cycle is the first of the next period, so it lasts 64 * N
        s_d.prescale = 6'h01;
        s_d.ticks = 16'h0000;
        s_d.tstate = RXFSC_T_WAIT;
      end
      default: begin
        s_d.tstate = RXFSC_T_OFF;
      end
    endcase
    // Data register access restarts the period
    if (s_q.tstate != RXFSC_T_OFF &&
        (fifo_in.data_rd || fifo_in.data_wr)) begin
      s_d.prescale = 6'h00;
      s_d.ticks = 16'h0000;
      s_d.tstate = RXFSC_T_WAIT;
    end
    if (!(s_q.ctrl.timer_mode && s_q.ctrl.frame_mode_enable) &&
        s_q.tstate != RXFSC_T_OFF) begin
      s_d.tstate = RXFSC_T_OFF;
      s_d.frame_req = 1'b0;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.ctrl.last_transfer_granularity <= `RXFSC_GR_RESET;
      s_q.ctrl.masks <= `RXFSC_MASK_RESET;
      s_q.empty <= 1'b1;
      s_q.tstate <= RXFSC_T_OFF;
      s_q.didx <= RXFSC_R_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  // Zero-wait slave; the flop copy keeps the output register-driven
  logic hreadyout_q;
  logic hresp_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  assign hrdata = s_q.hrdata;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign rx_fifo_error_event = s_q.err_evt;
  assign high_service_req = s_q.high_req;
  assign frame_service_req = s_q.frame_req;

endmodule : rxfsc_top

// *** rtl/rxfsc_consts.svh ***
// Offsets, field positions, reset values and timing counts of the receive
// FIFO status and control block. Definitions only; included by bare name.
//
// Summary of operation
// - Out-of-range pointer write sets sticky illegal pointer; one clears.
// - Control mask bits 23..19 keep matching flags off the error event.
// - Status bits 27..24 are one-hot, naming a frame boundary's byte lane.
// - Frame mode: rejecting an already read frame sets sticky accept error.
// - Writer stalled for lack of room sets sticky receive-wait; one clears.
// - Read pointer passing write pointer sets sticky underflow; one clears.
// - Write passing read sets sticky overflow; the writer normally stalls.
// - Frame ready shows, in frame mode only, while whole frames sit unread.
// - Full shows while no free space remains; clears after a read.
// - Alarm sets when free bytes < threshold; clears below granularity.
// - Empty shows while no data is held, also after reset.
// - High request drops when fewer bytes remain than the granularity.
// - Frame mode enable turns on frame tracking and overrides granularity.
// - Timer mode defers frame requests, then one every counter*64 cycles.
// - Data register access restarts the timer; alarm requests unaffected.
// - Reset sets the receive-wait mask and granularity to one.
// - Last-read-frame pointer holds byte after last fully read frame.
// - Last-read-frame pointer resets to zero; read-write; upper bits zero.
// - The FIFO holds 1024 bytes; pointers address bytes within it.
// - Alarm compares free bytes against a separately programmed threshold.
`ifndef RXFSC_CONSTS_SVH
`define RXFSC_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define RXFSC_STATUS_OFS 16'h9188
`define RXFSC_CTRL_OFS 16'h918C
`define RXFSC_LAST_READ_FRAME_POINTER_OFS 16'h9190

// ****************************************
// Field positions
// ****************************************
`define RXFSC_ST_IP 31
`define RXFSC_ST_LANES_LO 24
`define RXFSC_ST_FLAGS_LO 19
`define RXFSC_CT_TIMER 28
`define RXFSC_CT_FRAME_MODE_ENABLE 27
`define RXFSC_CT_GR_LO 24
`define RXFSC_CT_MASK_LO 19
`define RXFSC_CT_FIXED_LO 16

// ****************************************
// Sizes and reset values
// ****************************************
`define RXFSC_DEPTH 11'h400
`define RXFSC_PTR_MAX 16'h03FF
`define RXFSC_GR_RESET 3'h1
`define RXFSC_MASK_RESET 5'h04
`define RXFSC_CT_FIXED 3'h4

// ****************************************
// Timing: one timer tick every 64 clock cycles
// ****************************************
`define RXFSC_TICK_CYCLES 7'h40
`define RXFSC_PRESCALE_LAST 6'h3F

`endif

// *** rtl/rxfsc_pkg.sv ***
// Types of the receive FIFO status and control block.
// Assumes the constants header is compiled alongside.
package rxfsc_pkg;
  timeunit 1ns;
  timeprecision 1ns;

  // Sticky flags in status order 23..20 after the illegal pointer bit
  typedef struct packed {
    logic ip;
    logic fae;
    logic receive_wait_flag;
    logic uf;
    logic of;
  } rxfsc_flags_t;

  typedef struct packed {
    logic timer_mode;
    logic frame_mode_enable;
    logic [2:0] last_transfer_granularity;
    rxfsc_flags_t masks;
    logic [15:0] counter;
  } rxfsc_ctrl_t;

  // Events and levels from the FIFO datapath, same clock
  typedef struct packed {
    logic [10:0] level;
    logic [9:0] last_write_frame_ptr;
    logic [9:0] alarm_threshold;
    logic data_rd;
    logic data_wr;
    logic boundary_valid;
    logic [3:0] boundary_lanes;
    logic [9:0] frame_end_ptr;
    logic frame_rejected;
    logic mac_stall;
    logic underflow_evt;
    logic overflow_evt;
    logic ptr_wr;
    logic [15:0] ptr_wr_val;
  } rxfsc_fifo_in_t;

  typedef enum logic [2:0] {
    RXFSC_T_OFF = 3'b001,
    RXFSC_T_WAIT = 3'b010,
    RXFSC_T_FIRE = 3'b100
  } rxfsc_tstate_t;

  typedef enum logic [1:0] {
    RXFSC_R_NONE = 2'h0,
    RXFSC_R_STATUS = 2'h1,
    RXFSC_R_CTRL = 2'h2,
    RXFSC_R_LAST_READ_FRAME_POINTER = 2'h3
  } rxfsc_reg_t;

  typedef struct packed {
    rxfsc_ctrl_t ctrl;
    rxfsc_flags_t flags;
    logic [3:0] lanes;
    logic frame_ready;
    logic full;
    logic alarm;
    logic empty;
    logic [9:0] last_read_frame_pointer;
    rxfsc_tstate_t tstate;
    logic [5:0] prescale;
    logic [15:0] ticks;
    logic frame_req;
    logic err_evt;
    logic high_req;
    logic dwrite;
    rxfsc_reg_t didx;
    logic [31:0] hrdata;
  } rxfsc_state_t;

endpackage : rxfsc_pkg

// *** tb/rxfsc_monitor.sv ***
// Port-level checker of the receive FIFO status block.
// Assumes one AHB-Lite slave whose hreadyout returns as hready.
`include "rxfsc_consts.svh"
module rxfsc_monitor
  import rxfsc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Datapath and requests
  input wire rxfsc_fifo_in_t fifo_in,
  input wire logic rx_fifo_error_event,
  input wire logic high_service_req,
  input wire logic frame_service_req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rd_q;
  logic wr_q;
  logic evt;
  logic [15:0] a_q;
  assign evt = |{fifo_in.ptr_wr, fifo_in.frame_rejected, fifo_in.mac_stall,
    fifo_in.underflow_evt, fifo_in.overflow_evt};
  // Data phase owner, so reads can be judged by address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      a_q <= 16'h0;
    end else begin
      rd_q <= hsel & hready & htrans[1] & ~hwrite;
      wr_q <= hsel & hready & htrans[1] & hwrite;
      a_q <= {haddr[15:2], 2'h0};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************
  // Checks
  // ****************
  a_err_rise: assert property ($rose(rx_fifo_error_event) |->
    $past(evt, 2) || $past(wr_q, 2)) else $error("error event rose");
  a_err_fall: assert property ($fell(rx_fifo_error_event) |->
    $past(wr_q, 2)) else $error("error event fell unasked");
  a_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_last_read_frame_pointer_upper: assert property (rd_q && a_q == `RXFSC_LAST_READ_FRAME_POINTER_OFS |->
    hrdata[31:10] == 22'h0) else $error("pointer upper bits");
  a_status_shape: assert property (rd_q && a_q == `RXFSC_STATUS_OFS |->
    $onehot0(hrdata[27:24]) && hrdata[30:28] == 3'h0 &&
    hrdata[15:0] == 16'h0) else $error("status shape");
  a_ctrl_fixed: assert property (rd_q && a_q == `RXFSC_CTRL_OFS |->
    hrdata[31:29] == 3'h0 && hrdata[18:16] == 3'h4)
    else $error("control fixed bits");
  a_alarm_set: assert property (fifo_in.level >= 11'h008 &&
    (11'h400 - fifo_in.level) < {1'b0, fifo_in.alarm_threshold} |=>
    high_service_req) else $error("alarm not raised");
  a_alarm_hold: assert property (high_service_req &&
    fifo_in.level >= 11'h008 |=> high_service_req)
    else $error("alarm dropped early");
  c_err: cover property ($rose(rx_fifo_error_event));
  c_high: cover property ($rose(high_service_req));
  c_frame: cover property ($rose(frame_service_req));
endmodule : rxfsc_monitor

bind rxfsc_top rxfsc_monitor u_rxfsc_monitor (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .fifo_in(fifo_in),
  .rx_fifo_error_event(rx_fifo_error_event),
  .high_service_req(high_service_req),
  .frame_service_req(frame_service_req));

// *** tb/rxfsc_fifo_model.sv ***
// Far-side model: FIFO datapath and reader feeding the status inputs.
// Assumes callers enter its tasks just after a rising hclk edge.
module rxfsc_fifo_model
  import rxfsc_pkg::*;
(
  // Clock
  input wire logic hclk,
  // Datapath view
  output rxfsc_fifo_in_t fifo_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial fifo_in = '0;
  function automatic rxfsc_fifo_in_t mk(input int k, input logic [15:0] v,
                                        input logic [3:0] b);
    rxfsc_fifo_in_t f;
    f = fifo_in;
    f.ptr_wr = (k == 0);
    f.ptr_wr_val = v;
    f.frame_rejected = (k == 1);
    f.mac_stall = (k == 2);
    f.underflow_evt = (k == 3);
    f.overflow_evt = (k == 4);
    f.boundary_valid = (k == 5);
    f.boundary_lanes = b;
    f.frame_end_ptr = v[9:0];
    f.data_rd = (k == 6);
    f.data_wr = (k == 7);
    return f;
  endfunction : mk
  // one-cycle strobes; qualifiers inverted once released
  task automatic pulse(input int k, input logic [15:0] v,
                       input logic [3:0] b);
    fifo_in <= mk(k, v, b);
    @(posedge hclk);
    fifo_in <= mk(9, ~v, ~b);
  endtask : pulse
  task automatic lvl(input logic [10:0] l, input logic [9:0] t,
                     input logic [9:0] w);
    fifo_in.level <= l;
    fifo_in.alarm_threshold <= t;
    fifo_in.last_write_frame_ptr <= w;
  endtask : lvl
endmodule : rxfsc_fifo_model

// *** tb/rxfsc_top_tb.sv ***
// Bench for the receive FIFO status block: AHB register calls and
// far-side strobes. Assumes hreadyout loops back as hready.
`include "rxfsc_consts.svh"
module rxfsc_top_tb;
  import rxfsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] ST = `RXFSC_STATUS_OFS;
  localparam logic [15:0] CT = `RXFSC_CTRL_OFS;
  localparam logic [15:0] LR = `RXFSC_LAST_READ_FRAME_POINTER_OFS;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic rs;
  logic hreadyout;
  logic hresp;
  logic ev;
  logic hreq;
  logic freq;
  wire logic hready;
  rxfsc_fifo_in_t fifo_in;
  int errors = 0;
  int total_checks = 0;
  int n1;
  int n2;
  assign hready = hreadyout;
  always #50 hclk = ~hclk;
  rxfsc_top u_rxfsc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fifo_in(fifo_in),
    .rx_fifo_error_event(ev), .high_service_req(hreq),
    .frame_service_req(freq));
  rxfsc_fifo_model u_rxfsc_fifo_model (.hclk(hclk), .fifo_in(fifo_in));
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Read data is taken at the falling edge inside the data phase; write data at the edge that ends it
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [31:0] d);
    logic r;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {16'h0, a};
    do begin
      @(negedge hclk) r = hreadyout;
      @(posedge hclk);
    end while (r !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(negedge hclk) r = hreadyout;
      rd = hrdata;
      rs = hresp;
      @(posedge hclk);
    end while (r !== 1'b1);
  endtask : xfer
  task automatic rc(input logic [15:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk("register", e, rd);
    chk("response", 32'h00000000, {31'h0, rs});
  endtask : rc
  task automatic outs(input logic [2:0] e);
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk("event high frame", {29'h0, e}, {29'h0, ev, hreq, freq});
    @(posedge hclk);
  endtask : outs
  task automatic period(output int n);
    int k;
    n = 0;
    for (k = 0; k < 3000 && freq !== 1'b1; k++) @(negedge hclk);
    @(negedge hclk);
    while (freq !== 1'b1 && n < 3000) begin
      n++;
      @(negedge hclk);
    end
    @(posedge hclk);
  endtask : period
  function automatic logic [31:0] fb(input int i);
    return (i == 0) ? 32'h80000000 : 32'h01000000 >> i;
  endfunction : fb
  task automatic complete_run;
    if (errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    complete_run();
  end
  initial begin
    int i;
    int j;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(ST, 32'h00010000);
    rc(CT, 32'h01240000);
    rc(LR, 32'h00000000);
    rc(16'h9194, 32'h00000000);
    xfer(1'b1, LR, 32'hFFFFFFFF);
    rc(LR, 32'h000003FF);
    rc(ST, 32'h80010000);
    outs(3'h4);
    xfer(1'b1, ST, 32'h7FFFFFFF);
    rc(ST, 32'h80010000);
    xfer(1'b1, ST, 32'h80000000);
    rc(ST, 32'h00010000);
    xfer(1'b1, LR, 32'h0);
    for (i = 0; i < 5; i++) begin
      xfer(1'b1, CT, 32'h09F80000);
      u_rxfsc_fifo_model.pulse(i, 16'h0400, 4'h0);
      rc(ST, 32'h00010000 | fb(i));
      outs(3'h0);
      xfer(1'b1, CT, 32'h09F80000 & ~(32'h00800000 >> i));
      outs(3'h4);
      xfer(1'b1, ST, fb(i));
      rc(ST, 32'h00010000);
      outs(3'h0);
    end
    xfer(1'b1, CT, 32'h01000000);
    u_rxfsc_fifo_model.pulse(1, 16'h0, 4'h0);
    rc(ST, 32'h00010000);
    u_rxfsc_fifo_model.pulse(5, 16'h0155, 4'h8);
    rc(ST, 32'h08010000);
    rc(LR, 32'h0);
    xfer(1'b1, CT, 32'h09000000);
    u_rxfsc_fifo_model.pulse(5, 16'h0155, 4'h1);
    rc(LR, 32'h00000155);
    rc(ST, 32'h01090000);
    outs(3'h1);
    u_rxfsc_fifo_model.lvl(11'h0, 10'h0, 10'h155);
    outs(3'h0);
    rc(ST, 32'h01010000);
    u_rxfsc_fifo_model.lvl(11'h400, 10'h0, 10'h155);
    outs(3'h0);
    rc(ST, 32'h01040000);
    xfer(1'b1, CT, 32'h02000000);
    u_rxfsc_fifo_model.lvl(11'h3E8, 10'h064, 10'h155);
    outs(3'h2);
    rc(ST, 32'h01020000);
    u_rxfsc_fifo_model.lvl(11'h002, 10'h064, 10'h155);
    outs(3'h2);
    u_rxfsc_fifo_model.lvl(11'h001, 10'h064, 10'h155);
    outs(3'h0);
    xfer(1'b1, CT, 32'h0A000000);
    u_rxfsc_fifo_model.lvl(11'h3E8, 10'h064, 10'h155);
    outs(3'h2);
    u_rxfsc_fifo_model.lvl(11'h001, 10'h064, 10'h155);
    outs(3'h2);
    u_rxfsc_fifo_model.lvl(11'h000, 10'h064, 10'h155);
    outs(3'h0);
    xfer(1'b1, CT, 32'h18000001);
    u_rxfsc_fifo_model.lvl(11'h000, 10'h000, 10'h200);
    period(n1);
    xfer(1'b1, CT, 32'h18000002);
    period(n2);
    chk("timer period", 32'h00000040, 32'(n2 - n1));
    chk("timer period", 32'h0000003F, 32'(n1));
    // Restart mid-period: two 64-cycle ticks plus the output register
    for (j = 6; j < 8; j++) begin
      repeat (30) @(posedge hclk);
      u_rxfsc_fifo_model.pulse(j, 16'h0000, 4'h0);
      n1 = 0;
      @(negedge hclk);
      while (freq !== 1'b1 && n1 < 3000) begin
        n1++;
        @(negedge hclk);
      end
      @(posedge hclk);
      chk("timer restart", 32'h00000081, 32'(n1));
    end
    complete_run();
  end
endmodule : rxfsc_top_tb
